/* File: verilog/spk_gain_ctrl.sv */
`timescale 1ns/1ps
module spk_gain_ctrl
  import spk_gain_pkg::*;
#(
  parameter int WAKE_COUNT = WAKE_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  output logic POWER_DOWN_N,
  output logic MUTE_ACTIVE,
  output logic FACTORY_CHECK_ENABLE,
  output logic [5:0] GAIN_CODE,
  output logic signed [7:0] GAIN_DB,
  output logic GAIN_KNOWN,
  output logic AMP_READY
);

  localparam int WAKE_W = $clog2(WAKE_COUNT + 1);
  localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_COUNT - 1);
  localparam logic [2:0] LAST_BIT = 3'(BYTE_BITS - 1);

  // ==========================================================
  // Link domain and crossings
  // ==========================================================
  link_sample_t link_sample;
  link_sample_t link_s;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic tog_d;
  logic rise_q;

  // SCL is its own clock domain, so any rate to 400 kHz works
  scl_capture u_capture (
    .scl(SCL),
    .arst_n(ARST_N),
    .sda(SDA_I),
    .sample(link_sample)
  );

  bit_sync2 #(.WIDTH(2)) u_link_sync (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .d(link_sample),
    .q(link_s)
  );

  bit_sync2 #(.WIDTH(2)) u_pin_sync (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .d({SCL, SDA_I}),
    .q(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_d <= 1'b0;
      sda_d <= 1'b0;
      tog_d <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      tog_d <= link_s.tog;
      rise_q <= link_s.tog ^ tog_d;
    end
  end

  // ==========================================================
  // Bus event decode
  // ==========================================================
  logic start_cond;
  logic stop_cond;
  logic scl_fall;
  logic bit_take;
  logic [7:0] next_shift;
  logic byte_done;

  // frame edges seen only while clock is high
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_fall = scl_d & ~scl_s;

  // ==========================================================
  // Receive state machine
  // ==========================================================
  bus_state_t state;
  bus_state_t next_state;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic armed;
  logic ack_clocked;
  logic sda_oe;
  logic addr_match;
  logic is_rx;
  logic is_ack;

  // Bit is read one cycle after the toggle so the skew between the two
  // synchronised link bits cannot pick up a stale value.
  // data is stable across the high phase, so one sample suffices
  assign is_rx = (state == ST_ADDR) || (state == ST_DATA);
  assign is_ack = (state == ST_ADDR_ACK) || (state == ST_DATA_ACK);
  assign bit_take = rise_q & armed & is_rx;
  assign next_shift = {shift[6:0], link_s.bit_val};
  assign byte_done = bit_take && (bit_cnt == LAST_BIT);
  // full byte compare: a read direction bit never matches
  assign addr_match = (next_shift == DEV_ADDR_WR);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        next_state = ST_IDLE;
      end
      ST_ADDR: begin
        if (byte_done) begin
          // read requests and other addresses are dropped
          next_state = addr_match ? ST_ADDR_ACK : ST_IGNORE;
        end
      end
      ST_DATA: begin
        if (byte_done) begin
          next_state = ST_DATA_ACK;
        end
      end
      ST_ADDR_ACK, ST_DATA_ACK: begin
        // after every acknowledge another data byte may follow
        if (scl_fall && ack_clocked) begin
          next_state = ST_DATA;
        end
      end
      ST_IGNORE: begin
        next_state = ST_IGNORE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // STOP parks the machine; only START reopens it
    if (stop_cond) begin
      next_state = ST_IDLE;
    end else if (start_cond) begin
      next_state = ST_ADDR;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // A repeated START is preceded by a rising SCL whose event arrives late;
  // arming only after SCL is seen low keeps it out of the address byte.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      armed <= 1'b0;
    end else if (start_cond || stop_cond) begin
      armed <= 1'b0;
    end else if (!scl_s) begin
      armed <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_cnt <= 3'h0;
      shift <= 8'h00;
    end else if (start_cond || is_ack) begin
      bit_cnt <= 3'h0;
    end else if (bit_take) begin
      shift <= next_shift;
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // ==========================================================
  // Acknowledge drive
  // ==========================================================
  // Pull-down starts on the fall ending the eighth clock and ends on the
  // fall ending the ninth, so the master sees it for the whole high phase.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_clocked <= 1'b0;
      sda_oe <= 1'b0;
    end else if (!is_ack || start_cond || stop_cond) begin
      ack_clocked <= 1'b0;
      sda_oe <= 1'b0;
    end else if (scl_fall && !ack_clocked) begin
      // address ack and data ack in the ninth clock
      sda_oe <= 1'b1;
    end else if (rise_q) begin
      ack_clocked <= 1'b1;
    end else if (scl_fall && ack_clocked) begin
      sda_oe <= 1'b0;
    end
  end

  // ==========================================================
  // Control registers
  // ==========================================================
  mode_t mode;
  logic [5:0] gain_code;
  logic data_write;

  assign data_write = (state == ST_DATA) && byte_done;

  // async reset clears both registers; bus is dead while low
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode <= MODE_RESET;
      gain_code <= GAIN_RESET;
    end else if (data_write) begin
      // top bit selects the target register
      if (!next_shift[REG_SEL_BIT]) begin
        // reserved mode bits are not stored
        mode.power_down_n <= next_shift[MODE_POWER_BIT];
        mode.mute <= next_shift[MODE_MUTE_BIT];
        // factory check bit kept as written
        mode.factory_check_enable <= next_shift[MODE_FACTORY_BIT];
      end else begin
        gain_code <= next_shift[GAIN_MSB:0];
      end
    end
  end

  // ==========================================================
  // Wake delay
  // ==========================================================
  logic [WAKE_W-1:0] wake_cnt;
  logic wake_done;

  // count the wake delay from power-up release
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wake_cnt <= '0;
      wake_done <= 1'b0;
    end else if (!mode.power_down_n) begin
      wake_cnt <= '0;
      wake_done <= 1'b0;
    end else if (!wake_done) begin
      wake_cnt <= wake_cnt + 1'b1;
      wake_done <= (wake_cnt == WAKE_LAST);
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  logic signed [7:0] code_db;
  logic signed [7:0] next_gain_db;
  logic [5:0] next_gain_code;

  assign code_db = gain_to_db(gain_code);
  // mute overrides without touching the stored code
  assign next_gain_db = mode.mute ? DB_MUTE : code_db;
  assign next_gain_code = mode.mute ? GAIN_RESET : gain_code;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SDA_O <= 1'b0;
      SDA_OE <= 1'b0;
      POWER_DOWN_N <= 1'b0;
      MUTE_ACTIVE <= 1'b0;
      FACTORY_CHECK_ENABLE <= 1'b0;
      GAIN_CODE <= GAIN_RESET;
      GAIN_DB <= DB_MUTE;
      GAIN_KNOWN <= 1'b1;
      AMP_READY <= 1'b0;
    end else begin
      // only the data line is ever driven, and only low
      SDA_O <= 1'b0;
      SDA_OE <= sda_oe;
      // power-down leaves the registers as they are
      POWER_DOWN_N <= mode.power_down_n;
      MUTE_ACTIVE <= mode.mute;
      FACTORY_CHECK_ENABLE <= mode.factory_check_enable;
      GAIN_CODE <= next_gain_code;
      GAIN_DB <= next_gain_db;
      GAIN_KNOWN <= mode.mute || (gain_code <= GAIN_LAST_KNOWN);
      AMP_READY <= mode.power_down_n && wake_done;
    end
  end

endmodule

/* File: verilog/spk_gain_pkg.sv */
package spk_gain_pkg;

  // ==========================================================
  // Bus framing
  // ==========================================================
  localparam int BYTE_BITS = 8;
  localparam logic [7:0] DEV_ADDR_WR = 8'hde;
  localparam int SCL_MAX_KHZ = 400;
  localparam int REG_SEL_BIT = 7;

  // ==========================================================
  // Register fields and reset values
  // ==========================================================
  localparam int MODE_POWER_BIT = 0;
  localparam int MODE_MUTE_BIT = 1;
  localparam int MODE_FACTORY_BIT = 4;
  localparam int GAIN_MSB = 5;
  localparam logic [5:0] GAIN_RESET = 6'h00;
  localparam logic [5:0] GAIN_STEP3_FIRST = 6'h01;
  localparam logic [5:0] GAIN_STEP2_FIRST = 6'h07;
  localparam logic [5:0] GAIN_LAST_KNOWN = 6'h17;
  localparam logic signed [7:0] DB_MUTE = -8'sd90;
  localparam logic signed [7:0] DB_STEP3_BASE = -8'sd25;
  localparam logic signed [7:0] DB_STEP2_BASE = -8'sd8;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int WAKE_DELAY_US = 5000;
  localparam int WAKE_CYCLES = WAKE_DELAY_US * (SYS_CLK_HZ / 1_000_000);

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic factory_check_enable;
    logic mute;
    logic power_down_n;
  } mode_t;

  localparam mode_t MODE_RESET = 3'h0;

  typedef struct packed {
    logic tog;
    logic bit_val;
  } link_sample_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ADDR_ACK = 6'h04,
    ST_DATA = 6'h08,
    ST_DATA_ACK = 6'h10,
    ST_IGNORE = 6'h20
  } bus_state_t;

  // Codes above the last characterised step report 0 dB and are flagged unknown
  function automatic logic signed [7:0] gain_to_db(input logic [5:0] code);
    logic [7:0] c;
    c = {2'h0, code};
    if (code == GAIN_RESET) begin
      gain_to_db = DB_MUTE;
    end else if (code < GAIN_STEP2_FIRST) begin
      gain_to_db = DB_STEP3_BASE + 8'(3 * (c - {2'h0, GAIN_STEP3_FIRST}));
    end else if (code <= GAIN_LAST_KNOWN) begin
      gain_to_db = DB_STEP2_BASE + 8'(2 * (c - {2'h0, GAIN_STEP2_FIRST}));
    end else begin
      gain_to_db = 8'sh00;
    end
  endfunction

endpackage

/* File: verilog/bit_sync2.sv */
`timescale 1ns/1ps
module bit_sync2
  import spk_gain_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // First stage feeds only the second stage
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

/* File: verilog/scl_capture.sv */
`timescale 1ns/1ps
module scl_capture
  import spk_gain_pkg::*;
(
  input wire logic scl,
  input wire logic arst_n,
  input wire logic sda,
  output link_sample_t sample
);

  // ==========================================================
  // Link-domain sampling
  // ==========================================================
  // The bit stays stable for a whole SCL period, far longer than the
  // system-side synchroniser needs, so toggle plus data crosses safely.
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      sample <= 2'h0;
    end else begin
      sample.bit_val <= sda;
      sample.tog <= ~sample.tog;
    end
  end

endmodule

/* File: tb/spk_gain_ctrl_asserts.sv */
`timescale 1ns/1ps
module spk_gain_ctrl_asserts
  import spk_gain_pkg::*;
#(
  parameter int WAKE_COUNT = WAKE_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic SCL,
  input wire logic SDA_OE,
  input wire logic POWER_DOWN_N,
  input wire logic MUTE_ACTIVE,
  input wire logic [5:0] GAIN_CODE,
  input wire logic signed [7:0] GAIN_DB,
  input wire logic GAIN_KNOWN,
  input wire logic AMP_READY
);
  int on_cnt;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  // ==========================================================
  // Power-up age, saturating so it never wraps in long runs
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      on_cnt <= 0;
    end else if (!POWER_DOWN_N) begin
      on_cnt <= 0;
    end else if (on_cnt < WAKE_COUNT + 8) begin
      on_cnt <= on_cnt + 1;
    end
  end
  // ==========================================================
  // Acknowledge drive and register outputs
  oe_rise_a: assert property ($rose(SDA_OE) |-> !$past(SCL, 2) && $past(SCL, 6))
    else $error("Ack drive did not start after a clock fall");
  oe_fall_a: assert property ($fell(SDA_OE) |-> !$past(SCL, 2) && $past(SCL, 6))
    else $error("Ack drive did not end after a clock fall");
  oe_hold_a: assert property ($rose(SDA_OE) |-> SDA_OE [*8])
    else $error("Ack drive too short");
  mute_gain_a: assert property (MUTE_ACTIVE && $past(MUTE_ACTIVE) |->
    GAIN_CODE == 6'h00 && GAIN_DB == DB_MUTE) else $error("Mute did not force lowest gain");
  zero_db_a: assert property ($stable(GAIN_CODE) && GAIN_CODE == 6'h00 |->
    GAIN_DB == DB_MUTE && GAIN_KNOWN) else $error("Code zero not at mute gain");
  gain_known_a: assert property ($stable(GAIN_CODE) |->
    GAIN_KNOWN == (GAIN_CODE <= GAIN_LAST_KNOWN)) else $error("Known flag wrong");
  ready_early_a: assert property ($rose(AMP_READY) |-> on_cnt >= WAKE_COUNT - 1)
    else $error("Ready before wake delay");
  ready_late_a: assert property (on_cnt == WAKE_COUNT + 4 |-> AMP_READY)
    else $error("Ready late after wake delay");
  ready_off_a: assert property (!POWER_DOWN_N && !$past(POWER_DOWN_N) |-> !AMP_READY)
    else $error("Ready while powered down");
  reset_clear_a: assert property ($rose(ARST_N) |-> !POWER_DOWN_N && !MUTE_ACTIVE &&
    !AMP_READY && GAIN_CODE == 6'h00) else $error("Reset left state behind");
  cover property ($rose(SDA_OE));
  cover property ($rose(AMP_READY));
  cover property ($rose(MUTE_ACTIVE));
endmodule

/* File: tb/i2c_master_model.sv */
`timescale 1ns/1ps
module i2c_master_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  logic lclk;
  logic ack_v;
  event ack_ev;
  // ==========================================================
  // Link clock, free in phase; serial clock rests high between frames
  initial begin
    lclk = 1'b0;
    scl = 1'b1;
    sda_low = 1'b0;
    ack_v = 1'b0;
    #7;
    forever #15 lclk = ~lclk;
  end
  // three steps a bit keep the serial clock below 400 kHz
  task automatic step();
    repeat (28) @(posedge lclk);
  endtask
  task automatic start();
    step();
    sda_low <= 1'b1;
    step();
    scl <= 1'b0;
  endtask
  task automatic stop();
    step();
    sda_low <= 1'b1;
    step();
    scl <= 1'b1;
    step();
    sda_low <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      step();
      sda_low <= ~b[i];
      step();
      scl <= 1'b1;
      step();
      scl <= 1'b0;
    end
    step();
    sda_low <= 1'b0;
    step();
    scl <= 1'b1;
    step();
    ack_v = ~sda;
    -> ack_ev;
    scl <= 1'b0;
  endtask
endmodule

/* File: tb/spk_gain_ctrl_tb.sv */
`timescale 1ns/1ps
module spk_gain_ctrl_tb;
  localparam int WAKE = 20;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic scl, m_low, sda_oe, sda_o, pwr, mute, fac, known, ready;
  logic [5:0] code;
  logic [5:0] last;
  logic signed [7:0] db;
  logic ack_q[$];
  logic [5:0] tbl [6] = '{6'h01, 6'h06, 6'h07, 6'h17, 6'h18, 6'h00};
  logic [7:0] mb [4] = '{8'h03, 8'h01, 8'h11, 8'h00};
  logic [31:0] seed = 32'h0e8101f9;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #20 sys_clk = ~sys_clk;
  i2c_master_model m_u (.scl(scl), .sda_low(m_low), .sda(~(sda_oe | m_low)));
  spk_gain_ctrl #(.WAKE_COUNT(WAKE)) dut_u (
    .SYS_CLK(sys_clk), .ARST_N(arst_n), .SCL(scl), .SDA_I(~(sda_oe | m_low)), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .POWER_DOWN_N(pwr), .MUTE_ACTIVE(mute), .FACTORY_CHECK_ENABLE(fac),
    .GAIN_CODE(code), .GAIN_DB(db), .GAIN_KNOWN(known), .AMP_READY(ready));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] db_of(input logic [5:0] c);
    if (c == 6'h00) return 8'ha6;
    if (c < 6'h07) return 8'(3 * int'(c) - 28);
    if (c <= 6'h17) return 8'(2 * int'(c) - 22);
    return 8'h00;
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Mode m is {factory, mute, power}; mute hides the stored code
  task automatic regs(input logic [5:0] c, input logic [2:0] m);
    logic [5:0] e;
    e = m[1] ? 6'h00 : c;
    chk("mode", {5'h0, fac, mute, pwr}, {5'h0, m});
    chk("code", {2'h0, code}, {2'h0, e});
    chk("db", db, db_of(e));
    chk("known", {7'h0, known}, {7'h0, e <= 6'h17});
  endtask
  task automatic wr(input logic [7:0] b, input logic a);
    ack_q.push_back(a);
    m_u.send(b);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(m_u.ack_ev) begin
    chk("ack", {7'h0, m_u.ack_v}, {7'h0, ack_q.pop_front()});
    chk("sda_o", {7'h0, sda_o}, 8'h00);
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      conclude();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    regs(6'h00, 3'b000);
    $display("test reset done");
    m_u.start();
    wr(8'hde, 1'b1);
    wr(8'h6d, 1'b1);
    regs(6'h00, 3'b001);
    for (int i = 0; i < 10; i++) begin
      last = i < 6 ? tbl[i] : 6'(rnd() % 24);
      wr({2'b11, last}, 1'b1);
      regs(last, 3'b001);
    end
    m_u.stop();
    chk("ready", {7'h0, ready}, 8'h01);
    $display("test gain done");
    m_u.start();
    wr(8'hde, 1'b1);
    foreach (mb[i]) begin
      wr(mb[i], 1'b1);
      regs(last, {mb[i][4], mb[i][1:0]});
    end
    m_u.stop();
    chk("ready", {7'h0, ready}, 8'h00);
    $display("test mode done");
    m_u.start();
    wr(8'hdf, 1'b0);
    wr(8'h81, 1'b0);
    m_u.stop();
    m_u.start();
    wr(8'hdc, 1'b0);
    wr(8'h81, 1'b0);
    m_u.stop();
    wr(8'h85, 1'b0);
    m_u.stop();
    regs(last, 3'b000);
    $display("test refuse done");
    m_u.start();
    wr(8'hde, 1'b1);
    wr(8'h01, 1'b1);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    wr(8'h81, 1'b0);
    m_u.stop();
    regs(6'h00, 3'b000);
    @(posedge sys_clk);
    arst_n <= 1'b1;
    m_u.start();
    wr(8'hde, 1'b1);
    wr(8'h01, 1'b1);
    m_u.stop();
    regs(6'h00, 3'b001);
    $display("test reset mid-run done");
    conclude();
  end
endmodule

bind spk_gain_ctrl spk_gain_ctrl_asserts #(.WAKE_COUNT(WAKE_COUNT)) asrt_u (
  .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .SCL(SCL), .SDA_OE(SDA_OE), .POWER_DOWN_N(POWER_DOWN_N),
  .MUTE_ACTIVE(MUTE_ACTIVE), .GAIN_CODE(GAIN_CODE), .GAIN_DB(GAIN_DB), .GAIN_KNOWN(GAIN_KNOWN),
  .AMP_READY(AMP_READY));
